// ### logic/gpt_block.sv
/*
  Timer block slice: auxiliary counter with selectable count source
  (counter and incremental-interface modes) and the second core timer
  with prescaler, toggle latch, clear-on-capture and reload.
  Assumes pins and register strobes synchronous to ref_clk.
*/
`timescale 1ns/1ns
module gpt_block (
  input  wire logic                          ref_clk,
  input  wire logic                          nrst,
  input  wire gpt_pkg::reg_req_type          req,
  input  wire gpt_pkg::pins_type             pins,
  input  wire logic                          first_core_toggle_latch,
  output logic        [gpt_pkg::DATA_W-1:0]  rdata,
  output logic                               second_core_toggle_latch,
  output logic        [gpt_pkg::DATA_W-1:0]  aux_count
);
  import gpt_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] core2_ctrl_ff;
    logic [DATA_W-1:0] aux_ctrl_ff;
    logic [DATA_W-1:0] aux_cnt_ff;
    logic [DATA_W-1:0] core2_cnt_ff;
    logic [DATA_W-1:0] capture_reload_register_ff;
    logic [PRE_W-1:0]  pre_ff;
    logic              cnt_pin_ff;
    logic              dir_pin_ff;
    logic              otl_in_ff;
    logic [DATA_W-1:0] rdata_ff;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  logic [2:0]        aux_sel;
  logic [2:0]        aux_mode;
  logic [2:0]        core2_sel;
  logic [1:0]        bps;
  logic [3:0]        base;
  logic [4:0]        shift;
  logic [PRE_W:0]    ratio;
  logic [PRE_W-1:0]  pre_last;
  logic              core2_run;
  logic              cnt_rise;
  logic              cnt_fall;
  logic              dir_edge;
  logic              otl_rise;
  logic              otl_fall;
  logic              aux_tick;
  logic              aux_down;
  logic              core2_tick;
  logic              core2_wrap;
  logic              core2_down;

  assign aux_sel   = st_ff.aux_ctrl_ff[SEL_LSB+:3];
  assign aux_mode  = st_ff.aux_ctrl_ff[MODE_LSB+:3];
  assign core2_sel = st_ff.core2_ctrl_ff[SEL_LSB+:3];
  assign bps       = st_ff.core2_ctrl_ff[BPS_LSB+:2];
  assign core2_down = st_ff.core2_ctrl_ff[DIR_BIT];

  // edges against previous sampled value; inputs already synchronous
  assign cnt_rise = pins.count_pin & ~st_ff.cnt_pin_ff;
  assign cnt_fall = ~pins.count_pin & st_ff.cnt_pin_ff;
  assign dir_edge = pins.dir_pin ^ st_ff.dir_pin_ff;
  assign otl_rise = first_core_toggle_latch & ~st_ff.otl_in_ff;
  assign otl_fall = ~first_core_toggle_latch & st_ff.otl_in_ff;

  always_comb begin
    aux_tick = 1'b0;
    case (aux_mode)
      MODE_COUNTER: begin
        case (aux_sel[1:0])
          EDGE_NONE: aux_tick = 1'b0;
          EDGE_RISE: aux_tick = aux_sel[2] ? otl_rise : cnt_rise;
          EDGE_FALL: aux_tick = aux_sel[2] ? otl_fall : cnt_fall;
          EDGE_ANY:  aux_tick = aux_sel[2] ? (otl_rise | otl_fall)
                                           : (cnt_rise | cnt_fall);
          default:   aux_tick = 1'b0;
        endcase
      end
      MODE_INC_ROT, MODE_INC_EDG: begin
        // reserved 1XX codes treated as stop
        if (!aux_sel[2]) begin
          case (aux_sel[1:0])
            EDGE_NONE: aux_tick = 1'b0;
            EDGE_RISE: aux_tick = cnt_rise | cnt_fall;
            EDGE_FALL: aux_tick = dir_edge;
            EDGE_ANY:  aux_tick = cnt_rise | cnt_fall | dir_edge;
            default:   aux_tick = 1'b0;
          endcase
        end
      end
      default: aux_tick = 1'b0;
    endcase
  end

  // direction pin overrides software bit when enabled
  assign aux_down = st_ff.aux_ctrl_ff[XDIR_BIT] ? pins.dir_pin
                                                : st_ff.aux_ctrl_ff[DIR_BIT];

  always_comb begin
    case (bps)
      2'h0:    base = BPS_BASE_00;
      2'h1:    base = BPS_BASE_01;
      2'h2:    base = BPS_BASE_10;
      2'h3:    base = BPS_BASE_11;
      default: base = BPS_BASE_00;
    endcase
  end
  assign shift = {2'h0, core2_sel} + {1'b0, base};
  // one bit wider: the slowest ratio, 2048, does not fit the prescaler width
  assign ratio    = {1'b0, PRE_ONE} << shift;
  assign pre_last = PRE_W'(ratio - {1'b0, PRE_ONE});

  // only timer mode is implemented; reserved mode codes hold the timer
  assign core2_run  = st_ff.core2_ctrl_ff[RUN_BIT]
                    && (st_ff.core2_ctrl_ff[MODE_LSB+:3] == MODE_TIMER);
  // at or past the last count: a rate change mid-lap must not cost a full wrap
  assign core2_tick = core2_run && (st_ff.pre_ff >= pre_last);
  assign core2_wrap = core2_tick && (core2_down ? (st_ff.core2_cnt_ff == CNT_RESET)
                                                : (st_ff.core2_cnt_ff == CNT_MAX));

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cnt_pin_ff = pins.count_pin;
    nxt_st.dir_pin_ff = pins.dir_pin;
    nxt_st.otl_in_ff  = first_core_toggle_latch;

    if (aux_tick) begin
      nxt_st.aux_cnt_ff = aux_down ? st_ff.aux_cnt_ff - CNT_ONE
                                   : st_ff.aux_cnt_ff + CNT_ONE;
    end

    // prescaler restarts whenever the timer is held, so a start is phase-clean
    if (!core2_run || core2_tick) begin
      nxt_st.pre_ff = '0;
    end else begin
      nxt_st.pre_ff = st_ff.pre_ff + PRE_ONE;
    end

    if (core2_tick) begin
      nxt_st.core2_cnt_ff = core2_down ? st_ff.core2_cnt_ff - CNT_ONE
                                       : st_ff.core2_cnt_ff + CNT_ONE;
    end
    if (core2_wrap) begin
      nxt_st.core2_ctrl_ff[OTL_BIT] = ~st_ff.core2_ctrl_ff[OTL_BIT];
      if (st_ff.core2_ctrl_ff[SR_BIT]) begin
        nxt_st.core2_cnt_ff = st_ff.capture_reload_register_ff;
      end
    end
    // capture clear (CLR_BIT set) wins over counting in the same cycle
    if (pins.capture) begin
      nxt_st.capture_reload_register_ff = st_ff.aux_cnt_ff;
      if (st_ff.core2_ctrl_ff[CLR_BIT]) begin
        nxt_st.core2_cnt_ff = CNT_RESET;
      end
    end

    if (req.wr) begin
      case (req.addr)
        ADDR_CORE2_CTRL: nxt_st.core2_ctrl_ff = req.wdata & CORE2_WMASK;
        ADDR_AUX_CTRL:   nxt_st.aux_ctrl_ff = req.wdata & AUX_WMASK;
        ADDR_AUX_COUNT:  nxt_st.aux_cnt_ff = req.wdata;
        ADDR_CORE2_CNT:  nxt_st.core2_cnt_ff = req.wdata;
        ADDR_CAPTURE_RELOAD_REGISTER:     nxt_st.capture_reload_register_ff = req.wdata;
        default:         nxt_st.rdata_ff = st_ff.rdata_ff;
      endcase
    end

    nxt_st.rdata_ff = '0;
    if (req.rd) begin
      case (req.addr)
        ADDR_CORE2_CTRL: nxt_st.rdata_ff = st_ff.core2_ctrl_ff;
        ADDR_AUX_CTRL:   nxt_st.rdata_ff = st_ff.aux_ctrl_ff;
        ADDR_AUX_COUNT:  nxt_st.rdata_ff = st_ff.aux_cnt_ff;
        ADDR_CORE2_CNT:  nxt_st.rdata_ff = st_ff.core2_cnt_ff;
        ADDR_CAPTURE_RELOAD_REGISTER:     nxt_st.rdata_ff = st_ff.capture_reload_register_ff;
        default:         nxt_st.rdata_ff = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata_ff;
  assign second_core_toggle_latch = st_ff.core2_ctrl_ff[OTL_BIT];
  assign aux_count = st_ff.aux_cnt_ff;

  a_aux_idle_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_COUNTER && aux_sel[1:0] == EDGE_NONE && !req.wr)
      |=> $stable(aux_count))
    else $error("aux counter moved with no edge selected");
  a_aux_pin_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_COUNTER && aux_sel == 3'h1 && cnt_rise && !req.wr)
      |=> aux_count != $past(aux_count))
    else $error("rising pin edge missed");
  a_aux_latch_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_COUNTER && aux_sel == 3'h6 && otl_fall && !req.wr)
      |=> aux_count != $past(aux_count))
    else $error("falling latch edge missed");
  a_inc_stop: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_INC_ROT && aux_sel == 3'h0 && !req.wr) |=> $stable(aux_count))
    else $error("incremental stop ignored");
  a_inc_dir_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_INC_EDG && aux_sel == 3'h2 && dir_edge && !req.wr)
      |=> aux_count != $past(aux_count))
    else $error("direction pin edge missed");
  a_core_stopped: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!st_ff.core2_ctrl_ff[RUN_BIT] && !req.wr && !pins.capture)
      |=> $stable(st_ff.core2_cnt_ff))
    else $error("stopped timer counted");
  a_toggle_wrap: assert property (@(posedge ref_clk) disable iff (!nrst)
    (core2_wrap && !req.wr) |=> second_core_toggle_latch != $past(second_core_toggle_latch))
    else $error("latch did not toggle on wrap");
  a_capture_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pins.capture && st_ff.core2_ctrl_ff[CLR_BIT] && !req.wr)
      |=> st_ff.core2_cnt_ff == CNT_RESET)
    else $error("capture did not clear timer");
  a_prescale_span: assert property (@(posedge ref_clk) disable iff (!nrst)
    (core2_tick && !req.wr) |=> !core2_tick [*1])
    else $error("prescaler ticked twice in a row");
  a_aux_pin_fall: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_COUNTER && aux_sel == 3'h2 && cnt_fall && !req.wr)
      |=> aux_count != $past(aux_count))
    else $error("falling pin edge missed");
  a_aux_pin_either: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_COUNTER && aux_sel == 3'h3 && (cnt_rise || cnt_fall) && !req.wr)
      |=> aux_count != $past(aux_count))
    else $error("pin edge missed with either-edge select");
  a_aux_latch_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_COUNTER && aux_sel == 3'h5 && otl_rise && !req.wr)
      |=> aux_count != $past(aux_count))
    else $error("rising latch edge missed");
  a_aux_latch_any: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_COUNTER && aux_sel == 3'h7 && (otl_rise || otl_fall) && !req.wr)
      |=> aux_count != $past(aux_count))
    else $error("latch edge missed with either-edge select");
  a_pin_single_update: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode == MODE_COUNTER && aux_sel == 3'h1 && aux_tick && !req.wr)
      |=> !aux_tick)
    else $error("one pin edge counted twice");
  a_inc_pin_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
    ((aux_mode == MODE_INC_ROT || aux_mode == MODE_INC_EDG) && aux_sel == 3'h1
      && (cnt_rise || cnt_fall) && !req.wr) |=> aux_count != $past(aux_count))
    else $error("count pin edge missed in incremental mode");
  a_aux_mode_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_mode != MODE_COUNTER && aux_mode != MODE_INC_ROT && aux_mode != MODE_INC_EDG
      && !req.wr) |=> $stable(aux_count))
    else $error("aux counter moved outside its counting modes");
  a_aux_dir_pin: assert property (@(posedge ref_clk) disable iff (!nrst)
    (aux_tick && st_ff.aux_ctrl_ff[XDIR_BIT] && pins.dir_pin && !req.wr)
      |=> aux_count == $past(aux_count) - CNT_ONE)
    else $error("direction pin did not count down");
  a_core_bad_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
    (st_ff.core2_ctrl_ff[MODE_LSB+:3] != MODE_TIMER && !pins.capture && !req.wr)
      |=> $stable(st_ff.core2_cnt_ff))
    else $error("reserved mode moved the timer");
  a_core_up_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    (core2_tick && !core2_down && !core2_wrap && !pins.capture && !req.wr)
      |=> st_ff.core2_cnt_ff == $past(st_ff.core2_cnt_ff) + CNT_ONE)
    else $error("timer did not count up");
  a_core_down_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    (core2_tick && core2_down && !core2_wrap && !pins.capture && !req.wr)
      |=> st_ff.core2_cnt_ff == $past(st_ff.core2_cnt_ff) - CNT_ONE)
    else $error("timer did not count down");
  a_latch_sw_write: assert property (@(posedge ref_clk) disable iff (!nrst)
    (req.wr && req.addr == ADDR_CORE2_CTRL)
      |=> second_core_toggle_latch == $past(req.wdata[OTL_BIT]))
    else $error("latch not set by software write");
  a_reload_on_wrap: assert property (@(posedge ref_clk) disable iff (!nrst)
    (core2_wrap && st_ff.core2_ctrl_ff[SR_BIT] && !pins.capture && !req.wr)
      |=> st_ff.core2_cnt_ff == $past(st_ff.capture_reload_register_ff))
    else $error("timer not reloaded on wrap");
  a_capture_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pins.capture && !st_ff.core2_ctrl_ff[CLR_BIT] && !core2_tick && !req.wr)
      |=> $stable(st_ff.core2_cnt_ff))
    else $error("capture without clear moved the timer");
  a_prescale_step: assert property (@(posedge ref_clk) disable iff (!nrst)
    (core2_run && !core2_tick)
      |=> st_ff.pre_ff == $past(st_ff.pre_ff) + PRE_ONE)
    else $error("prescaler skipped a count");
endmodule : gpt_block

// ### logic/gpt_pkg.sv
/*
  Shared constants and carrier types for the timer block: register map,
  field positions, mode and input-select codes, prescaler figures.
  Assumes a single 25 MHz clock and a plain one-cycle register port.
*/
package gpt_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // register indices on the plain port
  localparam logic [ADDR_W-1:0] ADDR_CORE2_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_AUX_CTRL   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_AUX_COUNT  = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CORE2_CNT  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_RELOAD_REGISTER     = 4'h4;

  // field positions; SEL, MODE and DIR are used in both control registers, the rest in one only
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned MODE_LSB = 3;
  localparam int unsigned RUN_BIT = 6;
  localparam int unsigned DIR_BIT = 7;
  localparam int unsigned XDIR_BIT = 8;
  localparam int unsigned OTL_BIT = 10;
  localparam int unsigned BPS_LSB = 11;
  localparam int unsigned CLR_BIT = 14;
  localparam int unsigned SR_BIT = 15;

  // writable bits of the second core timer and auxiliary control words, then reset values
  localparam logic [DATA_W-1:0] CORE2_WMASK = 16'hDCFF;
  localparam logic [DATA_W-1:0] AUX_WMASK   = 16'h01FF;
  localparam logic [DATA_W-1:0] CTRL_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0] CNT_RESET   = 16'h0000;

  localparam logic [2:0] MODE_TIMER   = 3'h0;
  localparam logic [2:0] MODE_COUNTER = 3'h1;
  localparam logic [2:0] MODE_INC_ROT = 3'h6;
  localparam logic [2:0] MODE_INC_EDG = 3'h7;

  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY  = 2'h3;

  // prescaler: ratio = 2^(n + base), base from block prescaler code
  localparam logic [3:0] BPS_BASE_00 = 4'h2;
  localparam logic [3:0] BPS_BASE_01 = 4'h1;
  localparam logic [3:0] BPS_BASE_10 = 4'h4;
  localparam logic [3:0] BPS_BASE_11 = 4'h3;
  localparam int unsigned PRE_W = 11;
  localparam logic [PRE_W-1:0] PRE_ONE = 11'h001;
  localparam logic [DATA_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [DATA_W-1:0] CNT_MAX = 16'hFFFF;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic count_pin;
    logic dir_pin;
    logic capture;
  } pins_type;
endpackage : gpt_pkg

// ### tb/pin_model.sv
/*
  Model of the external count and direction pins of the auxiliary timer.
  Assumes the bench calls its tasks; pins change just after a clock edge.
*/
`timescale 1ns/1ns
module pin_model (
  input  wire logic ref_clk,
  output logic      count_pin,
  output logic      dir_pin
);
  // cycles a level is held after a change; raise it for a slow source
  int gap = 3;

  initial begin
    count_pin = 1'b0;
    dir_pin   = 1'b0;
  end

  task automatic edge_count();
    @(posedge ref_clk) count_pin <= ~count_pin;
    repeat (gap) @(posedge ref_clk);
    #1;
  endtask : edge_count

  task automatic set_dir(input logic lvl);
    @(posedge ref_clk) dir_pin <= lvl;
    repeat (gap) @(posedge ref_clk);
    #1;
  endtask : set_dir
endmodule : pin_model

// ### tb/tb.sv
/*
  Self-checking bench for the timer block: register port tasks, pin model.
  Assumes the package constants and the one-cycle read latency of the port.
*/
`timescale 1ns/1ns
module tb;
  import gpt_pkg::*;
  logic              ref_clk;
  logic              nrst;
  logic              fctl;
  logic              capture;
  logic              otl;
  logic              count_pin;
  logic              dir_pin;
  reg_req_type       req;
  pins_type          pins;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] aux_count;
  logic [DATA_W-1:0] v;
  logic [DATA_W-1:0] exp_aux;
  int                error_cnt;
  int                n_checks;

  assign pins = '{count_pin: count_pin, dir_pin: dir_pin, capture: capture};
  gpt_block gpt_block_i (.ref_clk(ref_clk), .nrst(nrst), .req(req), .pins(pins),
    .first_core_toggle_latch(fctl), .rdata(rdata), .second_core_toggle_latch(otl),
    .aux_count(aux_count));
  pin_model pin_model_i (.ref_clk(ref_clk), .count_pin(count_pin), .dir_pin(dir_pin));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk) req.wr <= 1'b0;
    // step off the edge so the caller sees settled outputs
    #1;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk) req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic chk(input string what, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic tgl_latch();
    @(posedge ref_clk) fctl <= ~fctl;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : tgl_latch

  task automatic pulse_capture();
    @(posedge ref_clk) capture <= 1'b1;
    @(posedge ref_clk) capture <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : pulse_capture

  // run eight prescaled ticks from zero; phase may cost or add one tick
  task automatic run_rate(input logic [DATA_W-1:0] ctrl, input int ratio);
    wr(ADDR_CORE2_CNT, 16'h0000);
    wr(ADDR_CORE2_CTRL, ctrl);
    repeat (ratio * 8 - 2) @(posedge ref_clk);
    wr(ADDR_CORE2_CTRL, 16'h0000);
    rd(ADDR_CORE2_CNT);
    chk("core2 ticks in range", 16'h0001, 16'(v >= 16'h7 && v <= 16'h9));
  endtask : run_rate

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    fctl = 1'b0;
    capture = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    exp_aux = 16'h0000;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(ADDR_CORE2_CTRL);
    chk("core2 ctrl reset", CTRL_RESET, v);
    chk("aux count reset", CNT_RESET, aux_count);
    // all ones: mode 111 holds the timer, so the latch only moves by the write
    wr(ADDR_CORE2_CTRL, 16'hFFFF);
    rd(ADDR_CORE2_CTRL);
    chk("core2 ctrl mask", CORE2_WMASK, v);
    chk("latch set by write", 16'h0001, 16'(otl));
    wr(ADDR_CORE2_CTRL, 16'h0000);
    chk("latch cleared by write", 16'h0000, 16'(otl));
    rd(4'hF);
    chk("unmapped read", 16'h0000, v);
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_AUX_CTRL, {10'h000, MODE_COUNTER, s[2:0]});
      pin_model_i.edge_count();
      pin_model_i.edge_count();
      tgl_latch();
      tgl_latch();
      exp_aux += (s[1:0] == 2'h0) ? 16'h0 : (s[1:0] == 2'h3) ? 16'h2 : 16'h1;
      chk("counter mode select", exp_aux, aux_count);
    end
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_AUX_CTRL, {10'h000, s[1] ? MODE_INC_EDG : MODE_INC_ROT, s[2:0]});
      pin_model_i.edge_count();
      pin_model_i.edge_count();
      pin_model_i.set_dir(1'b1);
      pin_model_i.set_dir(1'b0);
      exp_aux += (s == 0) ? 16'h0 : (s == 3) ? 16'h4 : 16'h2;
      chk("incremental select", exp_aux, aux_count);
    end
    wr(ADDR_AUX_CTRL, {7'h00, 1'b1, 1'b0, 1'b0, MODE_COUNTER, 3'h1});
    pin_model_i.set_dir(1'b1);
    pin_model_i.edge_count();
    pin_model_i.edge_count();
    chk("pin direction down", exp_aux - 16'h1, aux_count);
    wr(ADDR_CORE2_CNT, 16'h1234);
    repeat (20) @(posedge ref_clk);
    rd(ADDR_CORE2_CNT);
    chk("core2 stopped", 16'h1234, v);
    wr(ADDR_CORE2_CTRL, 16'h0048);
    repeat (20) @(posedge ref_clk);
    rd(ADDR_CORE2_CNT);
    chk("core2 reserved mode holds", 16'h1234, v);
    run_rate(16'h0040, 4);
    run_rate(16'h0840, 2);
    run_rate(16'h1040, 16);
    run_rate(16'h1840, 8);
    run_rate(16'h0847, 256);
    wr(ADDR_CORE2_CNT, 16'hFFFE);
    wr(ADDR_CORE2_CTRL, 16'h0840);
    repeat (12) @(posedge ref_clk);
    #1;
    chk("latch after overflow", 16'h0001, 16'(otl));
    wr(ADDR_CORE2_CTRL, 16'h0000);
    wr(ADDR_CORE2_CNT, 16'h0002);
    wr(ADDR_CORE2_CTRL, 16'h08C0);
    repeat (12) @(posedge ref_clk);
    #1;
    chk("latch after underflow", 16'h0001, 16'(otl));
    wr(ADDR_CORE2_CTRL, 16'h0000);
    rd(ADDR_CORE2_CNT);
    chk("down count wrapped", 16'h00FF, v >> 8);
    wr(ADDR_CAPTURE_RELOAD_REGISTER, 16'h0100);
    wr(ADDR_CORE2_CNT, 16'hFFFE);
    wr(ADDR_CORE2_CTRL, 16'h8840);
    repeat (12) @(posedge ref_clk);
    wr(ADDR_CORE2_CTRL, 16'h0000);
    rd(ADDR_CORE2_CNT);
    chk("reload after overflow", 16'h0010, v >> 4);
    wr(ADDR_CORE2_CNT, 16'h1234);
    pulse_capture();
    rd(ADDR_CORE2_CNT);
    chk("capture without clear", 16'h1234, v);
    wr(ADDR_CORE2_CTRL, 16'h4000);
    pulse_capture();
    rd(ADDR_CORE2_CNT);
    chk("capture with clear", 16'h0000, v);
    tally_and_finish();
  end
endmodule : tb
